//--- verilog/sbs_pkg.sv
package sbs_pkg;
	localparam int NUM_BANKS = 4;
	localparam int ADDR_W = 12;
	localparam int BANK_W = 2;
	localparam int AUTOCLOSE_ADDR_BIT = 10;
	localparam int REF_CLK_PERIOD_PS = 25000;
	localparam int TIMER_W = 8;
	localparam int BURST_LEN_DEFAULT = 4;
	// Times in ps, as the values that a speed grade would supply
	localparam int CLOSE_TO_IDLE_TIME_PS = 20000;
	localparam int OPEN_TO_COLUMN_TIME_PS = 20000;
	localparam int LAST_WRITE_TO_CLOSE_TIME_PS = 14000;
	localparam int REFRESH_CYCLE_TIME_PS = 70000;
	localparam int MODE_LOAD_SETTLE_TIME_PS = 20000;
	localparam int OPEN_TO_OPEN_TIME_PS = 14000;
	// Least times: round up, never below one cycle
	localparam int CLOSE_TO_IDLE_CYC = (CLOSE_TO_IDLE_TIME_PS
		+ REF_CLK_PERIOD_PS - 1) / REF_CLK_PERIOD_PS;
	localparam int OPEN_TO_COLUMN_CYC = (OPEN_TO_COLUMN_TIME_PS
		+ REF_CLK_PERIOD_PS - 1) / REF_CLK_PERIOD_PS;
	localparam int LAST_WRITE_TO_CLOSE_CYC = (LAST_WRITE_TO_CLOSE_TIME_PS
		+ REF_CLK_PERIOD_PS - 1) / REF_CLK_PERIOD_PS;
	localparam int REFRESH_CYCLE_CYC = (REFRESH_CYCLE_TIME_PS
		+ REF_CLK_PERIOD_PS - 1) / REF_CLK_PERIOD_PS;
	localparam int MODE_LOAD_SETTLE_CYC = (MODE_LOAD_SETTLE_TIME_PS
		+ REF_CLK_PERIOD_PS - 1) / REF_CLK_PERIOD_PS;
	localparam int OPEN_TO_OPEN_CYC = (OPEN_TO_OPEN_TIME_PS
		+ REF_CLK_PERIOD_PS - 1) / REF_CLK_PERIOD_PS;

	typedef struct packed {
		logic cke;
		logic csN;
		logic rasN;
		logic casN;
		logic weN;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
	} sbs_pins_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_OPENING = 4'h1,
		ST_ACTIVE = 4'h3,
		ST_WRITE = 4'h2,
		ST_WREC = 4'h6,
		ST_READ = 4'h7,
		ST_READ_AC = 4'h5,
		ST_CLOSING = 4'h4,
		ST_WRITE_AC = 4'hc,
		ST_WREC_AC = 4'hd,
		ST_REFRESH = 4'hf,
		ST_MODE_LOAD = 4'he
	} sbs_state_t;

	typedef enum logic [3:0] {
		DESELECT_CMD = 4'h0,
		IDLE_CYCLE_CMD = 4'h1,
		BURST_HALT_CMD = 4'h2,
		READ_CMD = 4'h3,
		STORE_BURST_CMD = 4'h4,
		ROW_OPEN_CMD = 4'h5,
		CLOSE_CMD = 4'h6,
		REFRESH_CMD = 4'h7,
		MODE_LOAD_CMD = 4'h8
	} sbs_cmd_t;
endpackage : sbs_pkg

//--- verilog/sbs_bank_tracker.sv
`timescale 1ns/10ps
`default_nettype none
module sbs_bank_tracker #(
	parameter int BURST_LEN = sbs_pkg::BURST_LEN_DEFAULT
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Memory interface pins
	input wire logic linkClk,
	input wire sbs_pkg::sbs_pins_t pins,
	// Bank status
	output var sbs_pkg::sbs_state_t [sbs_pkg::NUM_BANKS-1:0] bankState,
	output logic illegalCmd,
	output logic [sbs_pkg::BANK_W-1:0] illegalBank
);
	import sbs_pkg::*;

	localparam int BC_W = $clog2(BURST_LEN + 1);
	localparam logic [BC_W-1:0] BURST_LOAD = BC_W'(BURST_LEN - 1);

	logic linkMeta_ff, linkSync_ff, linkPrev_ff;
	sbs_pins_t pinMeta_ff, pinSync_ff;
	logic ckePrev_ff;
	logic linkRise, decodeEn;
	sbs_cmd_t cmd;
	logic autoBit;
	logic [NUM_BANKS-1:0] hit, bad;
	sbs_state_t [NUM_BANKS-1:0] state_ff;
	logic [NUM_BANKS-1:0][TIMER_W-1:0] timer_ff;
	logic [NUM_BANKS-1:0][BC_W-1:0] burst_ff;
	logic [NUM_BANKS-1:0] haltSeen_ff;
	logic [TIMER_W-1:0] openGap_ff;
	logic illegal_ff;
	logic [BANK_W-1:0] illegalBank_ff;

	// Pins come from another clock: two stages before use
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			linkMeta_ff <= 1'b0;
			linkSync_ff <= 1'b0;
			linkPrev_ff <= 1'b0;
			pinMeta_ff <= '0;
			pinSync_ff <= '0;
		end
		else
		begin
			linkMeta_ff <= linkClk;
			linkSync_ff <= linkMeta_ff;
			linkPrev_ff <= linkSync_ff;
			pinMeta_ff <= pins;
			pinSync_ff <= pinMeta_ff;
		end
	end

	assign linkRise = linkSync_ff & ~linkPrev_ff;

	// Clock gate seen at the previous link edge
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			ckePrev_ff <= 1'b0;
		else if (linkRise)
			ckePrev_ff <= pinSync_ff.cke;
	end

	assign decodeEn = linkRise & pinSync_ff.cke & ckePrev_ff;
	assign autoBit = pinSync_ff.addr[AUTOCLOSE_ADDR_BIT];

	always_comb
	begin
		cmd = DESELECT_CMD;
		if (!pinSync_ff.csN)
		begin
			case ({pinSync_ff.rasN, pinSync_ff.casN, pinSync_ff.weN})
				3'h7: cmd = IDLE_CYCLE_CMD;
				3'h6: cmd = BURST_HALT_CMD;
				3'h5: cmd = READ_CMD;
				3'h4: cmd = STORE_BURST_CMD;
				3'h3: cmd = ROW_OPEN_CMD;
				3'h2: cmd = CLOSE_CMD;
				3'h1: cmd = REFRESH_CMD;
				default: cmd = MODE_LOAD_CMD;
			endcase
		end
	end

	// Which banks a command reaches, and whether it is illegal there
	always_comb
	begin
		for (int b = 0; b < NUM_BANKS; b++)
		begin
			case (cmd)
				DESELECT_CMD, IDLE_CYCLE_CMD, REFRESH_CMD, MODE_LOAD_CMD:
					hit[b] = 1'b1;
				CLOSE_CMD:
					hit[b] = autoBit || (pinSync_ff.bank == BANK_W'(b));
				default:
					hit[b] = (pinSync_ff.bank == BANK_W'(b));
			endcase
			case (state_ff[b])
				ST_IDLE:
					bad[b] = (cmd == READ_CMD) || (cmd == STORE_BURST_CMD)
						|| ((cmd == ROW_OPEN_CMD) && (openGap_ff != '0));
				ST_ACTIVE:
					bad[b] = (cmd == ROW_OPEN_CMD) || (cmd == REFRESH_CMD)
						|| (cmd == MODE_LOAD_CMD);
				ST_READ, ST_WRITE:
					bad[b] = (cmd == ROW_OPEN_CMD) || (cmd == REFRESH_CMD)
						|| (cmd == MODE_LOAD_CMD);
				ST_READ_AC, ST_WRITE_AC, ST_OPENING:
					bad[b] = (cmd != DESELECT_CMD) && (cmd != IDLE_CYCLE_CMD);
				ST_CLOSING:
					bad[b] = (cmd != DESELECT_CMD) && (cmd != IDLE_CYCLE_CMD)
						&& (cmd != CLOSE_CMD);
				ST_WREC:
					bad[b] = (cmd == ROW_OPEN_CMD) || (cmd == CLOSE_CMD)
						|| (cmd == REFRESH_CMD) || (cmd == MODE_LOAD_CMD);
				default:
					bad[b] = (cmd != DESELECT_CMD) && (cmd != IDLE_CYCLE_CMD)
						&& (cmd != BURST_HALT_CMD);
			endcase
			bad[b] = bad[b] & hit[b];
		end
	end

	// Per-bank state; illegal commands leave the bank untouched
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= {NUM_BANKS{ST_IDLE}};
			timer_ff <= '0;
			burst_ff <= '0;
			haltSeen_ff <= '0;
		end
		else
		begin
			for (int b = 0; b < NUM_BANKS; b++)
			begin
				if (timer_ff[b] != '0)
					timer_ff[b] <= timer_ff[b] - 1'b1;
				if (decodeEn && hit[b] && !bad[b] && (cmd != DESELECT_CMD)
					&& (cmd != IDLE_CYCLE_CMD) && (cmd != BURST_HALT_CMD
					|| state_ff[b] inside {ST_READ, ST_WRITE, ST_WREC_AC}))
				begin
					case (cmd)
						ROW_OPEN_CMD:
						begin
							state_ff[b] <= ST_OPENING;
							timer_ff[b] <= TIMER_W'(OPEN_TO_COLUMN_CYC);
						end
						READ_CMD, STORE_BURST_CMD:
						begin
							burst_ff[b] <= BURST_LOAD;
							if (cmd == READ_CMD)
								state_ff[b] <= autoBit ? ST_READ_AC : ST_READ;
							else
								state_ff[b] <= autoBit ? ST_WRITE_AC : ST_WRITE;
						end
						CLOSE_CMD:
						begin
							// Close to a bank already closing restarts nothing
							if (state_ff[b] != ST_CLOSING && state_ff[b] != ST_IDLE)
							begin
								state_ff[b] <= ST_CLOSING;
								timer_ff[b] <= TIMER_W'(CLOSE_TO_IDLE_CYC);
							end
						end
						REFRESH_CMD:
						begin
							state_ff[b] <= ST_REFRESH;
							timer_ff[b] <= TIMER_W'(REFRESH_CYCLE_CYC);
						end
						MODE_LOAD_CMD:
						begin
							state_ff[b] <= ST_MODE_LOAD;
							timer_ff[b] <= TIMER_W'(MODE_LOAD_SETTLE_CYC);
						end
						BURST_HALT_CMD:
						begin
							if (state_ff[b] == ST_WREC_AC)
								haltSeen_ff[b] <= 1'b1;
							else
								state_ff[b] <= ST_ACTIVE;
						end
						default:
							state_ff[b] <= state_ff[b];
					endcase
				end
				else if (decodeEn && state_ff[b] inside {ST_READ, ST_WRITE,
					ST_READ_AC, ST_WRITE_AC})
				begin
					// Burst advances one word per decoded link edge (clock gate high on it and on the one before)
					if (burst_ff[b] != '0)
						burst_ff[b] <= burst_ff[b] - 1'b1;
					else
					begin
						case (state_ff[b])
							ST_READ:
								state_ff[b] <= ST_ACTIVE;
							ST_READ_AC:
							begin
								state_ff[b] <= ST_CLOSING;
								timer_ff[b] <= TIMER_W'(CLOSE_TO_IDLE_CYC);
							end
							ST_WRITE_AC:
							begin
								state_ff[b] <= ST_WREC_AC;
								haltSeen_ff[b] <= 1'b0;
								timer_ff[b] <= TIMER_W'(LAST_WRITE_TO_CLOSE_CYC);
							end
							default:
							begin
								state_ff[b] <= ST_WREC;
								timer_ff[b] <= TIMER_W'(LAST_WRITE_TO_CLOSE_CYC);
							end
						endcase
					end
				end
				else if (timer_ff[b] == '0)
				begin
					case (state_ff[b])
						ST_CLOSING, ST_REFRESH, ST_MODE_LOAD:
							state_ff[b] <= ST_IDLE;
						ST_OPENING, ST_WREC:
							state_ff[b] <= ST_ACTIVE;
						ST_WREC_AC:
						begin
							if (haltSeen_ff[b])
								state_ff[b] <= ST_ACTIVE;
							else
							begin
								state_ff[b] <= ST_CLOSING;
								timer_ff[b] <= TIMER_W'(CLOSE_TO_IDLE_CYC);
							end
						end
						default:
							state_ff[b] <= state_ff[b];
					endcase
				end
			end
		end
	end

	// Spacing between row opens to any two banks
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			openGap_ff <= '0;
		else if (decodeEn && cmd == ROW_OPEN_CMD && !(|bad))
			openGap_ff <= TIMER_W'(OPEN_TO_OPEN_CYC);
		else if (openGap_ff != '0)
			openGap_ff <= openGap_ff - 1'b1;
	end

	// One-cycle report of a refused command; lowest bank wins
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			illegal_ff <= 1'b0;
			illegalBank_ff <= '0;
		end
		else
		begin
			illegal_ff <= decodeEn && (|bad);
			if (decodeEn && (|bad))
			begin
				for (int b = NUM_BANKS - 1; b >= 0; b--)
				begin
					if (bad[b])
						illegalBank_ff <= BANK_W'(b);
				end
			end
		end
	end

	assign bankState = state_ff;
	assign illegalCmd = illegal_ff;
	assign illegalBank = illegalBank_ff;
endmodule : sbs_bank_tracker
`default_nettype wire

//--- verif/sbs_checker.sv
`timescale 1ns/10ps
`default_nettype none
module sbs_checker #(
	parameter int BURST_LEN = 4
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Link side
	input wire logic linkClk,
	input wire sbs_pkg::sbs_pins_t pins,
	// Status
	input wire sbs_pkg::sbs_state_t [3:0] bankState,
	input wire logic illegalCmd,
	input wire logic [1:0] illegalBank
);
	import sbs_pkg::*;
	// One cycle of slack over the timer's N+1
	localparam int T_OPEN = OPEN_TO_COLUMN_CYC + 2;
	localparam int T_CLOSE = CLOSE_TO_IDLE_CYC + 2;
	localparam int T_WREC = LAST_WRITE_TO_CLOSE_CYC + 2;
	localparam int T_REF = REFRESH_CYCLE_CYC + 2;
	localparam int T_MODE = MODE_LOAD_SETTLE_CYC + 2;
	sbs_state_t s0;
	assign s0 = bankState[0];
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	sequence s_closeDone;
		##[1:T_CLOSE] s0 == ST_IDLE;
	endsequence
	sequence s_recDone;
		##[1:T_WREC] s0 inside {ST_CLOSING, ST_ACTIVE};
	endsequence
	property p_open;
		$rose(s0 == ST_OPENING) |-> ##[1:T_OPEN] s0 == ST_ACTIVE;
	endproperty
	a_open: assert property (p_open)
		else $error("opening overstays");
	property p_close;
		$rose(s0 == ST_CLOSING) |-> s_closeDone;
	endproperty
	a_close: assert property (p_close)
		else $error("closing overstays");
	property p_rdAc;
		s0 == ST_READ_AC |=> s0 inside {ST_READ_AC, ST_CLOSING};
	endproperty
	a_rdAc: assert property (p_rdAc)
		else $error("bad read burst exit");
	property p_wrAc;
		s0 == ST_WRITE_AC |=> s0 inside {ST_WRITE_AC, ST_WREC_AC};
	endproperty
	a_wrAc: assert property (p_wrAc)
		else $error("bad store burst exit");
	property p_wrecAc;
		$rose(s0 == ST_WREC_AC) |-> s_recDone;
	endproperty
	a_wrecAc: assert property (p_wrecAc)
		else $error("recovery with close stuck");
	property p_wrec;
		$rose(s0 == ST_WREC) |-> ##[1:T_WREC] s0 == ST_ACTIVE;
	endproperty
	a_wrec: assert property (p_wrec)
		else $error("recovery stuck");
	property p_ref;
		$rose(s0 == ST_REFRESH) |-> ##[1:T_REF] s0 == ST_IDLE;
	endproperty
	a_ref: assert property (p_ref)
		else $error("refresh overstays");
	property p_mode;
		$rose(s0 == ST_MODE_LOAD) |-> ##[1:T_MODE] s0 == ST_IDLE;
	endproperty
	a_mode: assert property (p_mode)
		else $error("mode load overstays");
	property p_quiet;
		$rose(linkClk) && (pins.csN || !pins.cke) |-> !illegalCmd [*6];
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("refusal on ignored edge");
endmodule : sbs_checker
bind sbs_bank_tracker sbs_checker #(.BURST_LEN(BURST_LEN)) u_chk (
	.ref_clk(ref_clk), .rst(rst), .linkClk(linkClk), .pins(pins),
	.bankState(bankState), .illegalCmd(illegalCmd),
	.illegalBank(illegalBank)
);
`default_nettype wire

//--- verif/sbs_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module sbs_ctrl_model (
	// Request from the bench
	input wire sbs_pkg::sbs_pins_t reqPins,
	// Link pins
	output logic linkClk,
	output var sbs_pkg::sbs_pins_t pins
);
	import sbs_pkg::*;
	// Free running, phase unrelated to ref_clk
	initial
	begin
		linkClk = 1'b0;
		#7;
		forever #100 linkClk = ~linkClk;
	end
	// Launch on the fall so pins are settled at the rise
	always @(negedge linkClk)
	begin
		pins <= reqPins;
	end
endmodule : sbs_ctrl_model
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import sbs_pkg::*;
	localparam logic [3:0] K_NOP = 4'h7;
	localparam logic [3:0] K_BST = 4'h6;
	localparam logic [3:0] K_RD = 4'h5;
	localparam logic [3:0] K_WR = 4'h4;
	localparam logic [3:0] K_ACT = 4'h3;
	localparam logic [3:0] K_PRE = 4'h2;
	localparam logic [3:0] K_REF = 4'h1;
	localparam logic [3:0] K_MRS = 4'h0;
	logic ref_clk;
	logic rst;
	logic linkClk;
	sbs_pins_t reqPins;
	sbs_pins_t pins;
	sbs_state_t [3:0] bankState;
	logic illegalCmd;
	logic [1:0] illegalBank;
	logic [1:0] expQ[$];
	int n_errors;
	int n_checks;
	sbs_ctrl_model u_ctrl (.reqPins(reqPins), .linkClk(linkClk), .pins(pins));
	sbs_bank_tracker u_dut (.ref_clk(ref_clk), .rst(rst), .linkClk(linkClk),
		.pins(pins), .bankState(bankState), .illegalCmd(illegalCmd),
		.illegalBank(illegalBank));
	function automatic logic [11:0] r12();
		return 12'($urandom());
	endfunction : r12
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	// Deselect afterwards so a command is never launched twice
	task automatic issue(input logic [3:0] c, input logic [1:0] b,
		input logic [11:0] a, input logic ck = 1'b1);
		@(posedge linkClk);
		@(posedge ref_clk);
		reqPins <= {ck, c, b, a};
		@(negedge linkClk);
		@(posedge ref_clk);
		reqPins <= {2'h3, 3'($urandom()), 2'($urandom()), r12()};
	endtask : issue
	// Decode lands two cycles after the link rise, then state one later
	task automatic lookAt(input int b, input sbs_state_t s, input int n);
		@(posedge linkClk);
		repeat (n) @(posedge ref_clk);
		chk(16'(bankState[b]), 16'(s));
	endtask : lookAt
	task automatic look(input int b, input sbs_state_t s);
		lookAt(b, s, 6);
	endtask : look
	task automatic tally_and_finish;
		chk(16'(expQ.size()), 16'h0);
		$display("checks %0d, errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish
	// Each refusal takes the oldest note
	always @(posedge ref_clk)
	begin
		if (illegalCmd === 1'b1)
			chk(16'(illegalBank), expQ.size() ? 16'(expQ.pop_front()) : 16'hffff);
	end
	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		tally_and_finish();
	end
	initial
	begin
		void'($urandom(32'h29d7));
		rst = 1'b1;
		reqPins = '1;
		n_errors = 0;
		n_checks = 0;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk(bankState, {4{ST_IDLE}});
		// Gate low now, then low on the previous edge
		issue(K_ACT, 2'h0, r12(), 1'b0);
		issue(K_ACT, 2'h0, r12());
		look(0, ST_IDLE);
		repeat (6) issue({1'b1, 3'($urandom())}, 2'($urandom()), r12());
		look(0, ST_IDLE);
		issue(K_ACT, 2'h0, r12());
		look(0, ST_ACTIVE);
		issue(K_RD, 2'h0, r12() | 12'h400);
		expQ.push_back(2'h0);
		issue(K_BST, 2'h0, r12());
		issue(K_ACT, 2'h2, r12());
		chk(16'(bankState[0]), 16'(ST_READ_AC));
		repeat (4) issue(K_NOP, 2'($urandom()), r12());
		look(0, ST_IDLE);
		look(2, ST_ACTIVE);
		issue(K_ACT, 2'h0, r12());
		issue(K_WR, 2'h0, r12() | 12'h400);
		expQ.push_back(2'h0);
		issue(K_REF, 2'h0, r12());
		expQ.push_back(2'h0);
		issue(K_BST, 2'h0, r12());
		chk(16'(bankState[0]), 16'(ST_WRITE_AC));
		repeat (4) issue(K_NOP, 2'($urandom()), r12());
		look(0, ST_IDLE);
		issue(K_ACT, 2'h0, r12());
		issue(K_WR, 2'h0, r12() & 12'hbff);
		repeat (4) issue(K_NOP, 2'($urandom()), r12());
		look(0, ST_ACTIVE);
		issue(K_PRE, 2'($urandom()), 12'h400);
		look(0, ST_IDLE);
		chk(bankState, {4{ST_IDLE}});
		issue(K_REF, 2'h0, r12());
		lookAt(0, ST_REFRESH, 4);
		look(0, ST_IDLE);
		issue(K_MRS, 2'h0, r12());
		lookAt(0, ST_MODE_LOAD, 4);
		look(0, ST_IDLE);
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
